// File: src/avlps_pkg.sv
package avlps_pkg;

    // Link geometry
    localparam int CHAN_N   = 3;
    localparam int CHAR_W   = 10;
    localparam int CTL_BITS = 2;
    localparam int ISL_BITS = 4;
    localparam int VID_BITS = 8;

    // Period timing in pixel clocks, packets per island capped at PKT_MAX
    localparam int CTRL_MIN_LEN = 12;
    localparam int PRE_LEN      = 8;
    localparam int GUARD_LEN    = 2;
    localparam int PKT_LEN      = 32;
    localparam int PKT_MAX      = 18;
    localparam int EXT_MIN_LEN  = 32;

    // Extended control spacing
    localparam int EXT_GAP_MS     = 50;
    localparam int PIX_CLK_KHZ    = 166666;
    localparam int EXT_GAP_CYC    = EXT_GAP_MS * PIX_CLK_KHZ;
    localparam int EXT_MARGIN_CYC = 4096;

    // Derived counter limits
    localparam logic [5:0] CNT_SAT     = 6'h3F;
    localparam logic [5:0] PRE_GO_MIN  = 6'(CTRL_MIN_LEN - PRE_LEN - 1);
    localparam logic [5:0] PRE_GO_EXT  = 6'(EXT_MIN_LEN - PRE_LEN - 1);
    localparam logic [5:0] EXT_MARK    = 6'(EXT_MIN_LEN - 1);
    localparam logic [2:0] PRE_LAST    = 3'(PRE_LEN - 1);
    localparam logic       GB_LAST     = 1'(GUARD_LEN - 1);
    localparam logic [4:0] PKT_LAST    = 5'(PKT_LEN - 1);
    localparam logic [4:0] PKT_MAX_CNT = 5'(PKT_MAX);

    // Period control flag codes, bit 0 is flag 0
    localparam logic [3:0] CTL_IDLE       = 4'h0;
    localparam logic [3:0] CTL_PRE_VIDEO  = 4'h1;
    localparam logic [3:0] CTL_PRE_ISLAND = 4'h5;
    localparam logic [3:0] CTL_ENCRYPTION_ENABLE_CODE     = 4'h9;

    // Guard band characters
    localparam logic [9:0] GB_VID_CH02     = 10'h2CC;
    localparam logic [9:0] GB_CH12         = 10'h133;
    localparam logic [1:0] ISL_GB_CH0_HIGH = 2'h3;

    typedef enum logic [1:0] {
        KIND_CTRL  = 2'h0,
        KIND_VIDEO = 2'h1,
        KIND_ERROR_REDUCTION_4B10B_CODING = 2'h2,
        KIND_GUARD = 2'h3
    } avlps_kind_t;

    typedef enum logic [2:0] {
        ST_CTRL   = 3'h0,
        ST_PRE    = 3'h1,
        ST_LEAD   = 3'h3,
        ST_VIDEO  = 3'h2,
        ST_ISLAND = 3'h6,
        ST_TRAIL  = 3'h7
    } avlps_state_t;

endpackage : avlps_pkg

// File: src/avlps_seq.sv
`timescale 1ns/100ps
module avlps_seq
    import avlps_pkg::*;
#(
    parameter int unsigned P_EXT_GAP_CYC = EXT_GAP_CYC,
    parameter int unsigned P_EXT_MARGIN  = EXT_MARGIN_CYC,
    parameter int unsigned P_TMR_W       = 24
) (
    // System domain
    input  wire logic                i_clk_sys,
    input  wire logic                i_sys_rst,
    input  wire logic                i_sys_enable,
    output logic                     o_sys_active,
    output logic                     o_sys_ext_late,

    // Pixel clock and control inputs
    input  wire logic                i_clk_pix,
    input  wire logic                i_pix_hsync,
    input  wire logic                i_pix_vsync,
    input  wire logic [3:0]          i_pix_ctl_flags,
    input  wire logic                i_pix_enc_window,

    // Video stream
    input  wire logic                i_vid_req,
    input  wire logic [23:0]         i_vid_data,
    output logic                     o_vid_take,

    // Island stream
    input  wire logic                i_isl_req,
    input  wire logic [4:0]          i_isl_pkt_cnt,
    input  wire logic                i_isl_hdr_bit,
    input  wire logic [3:0]          i_isl_ch1,
    input  wire logic [3:0]          i_isl_ch2,
    output logic                     o_isl_take,
    output logic                     o_isl_pkt_first,

    // Channel symbols to encoders
    output logic                     o_clk_chan_run,
    output logic [1:0]               o_ch0_kind,
    output logic [CHAR_W-1:0]        o_ch0_char,
    output logic [1:0]               o_ch1_kind,
    output logic [CHAR_W-1:0]        o_ch1_char,
    output logic [1:0]               o_ch2_kind,
    output logic [CHAR_W-1:0]        o_ch2_char
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [1:0]               pix_rst_q;
    logic                     pix_rst;
    logic                     en_sys_q;
    logic                     en_meta_q;
    logic                     en_sync_q;
    logic                     act_pix_q;
    logic                     late_pix_q;
    logic                     act_meta_q;
    logic                     late_meta_q;

    avlps_state_t             state_q;
    avlps_state_t             state_d;
    logic                     start_vid;
    logic                     start_isl;
    logic                     is_vid_q;
    logic [5:0]               ctrl_cnt_q;
    logic [5:0]               pre_go;
    logic [2:0]               pre_cnt_q;
    logic                     gb_cnt_q;
    logic [4:0]               pkt_clk_q;
    logic [4:0]               pkt_left_q;
    logic [4:0]               pkt_load;
    logic [P_TMR_W-1:0]       ext_tmr_q;
    logic                     need_ext_q;
    logic                     in_ctrl;
    logic                     pkt_first_d;
    logic                     vid_take_q;
    logic                     isl_take_q;
    logic                     pkt_first_q;
    logic                     clk_run_q;

    logic [3:0]               flags_out;
    logic [5:0]               ctl6;
    logic [11:0]              isl12;
    logic [3:0]               isl_gb0;
    avlps_kind_t              kind_d [CHAN_N];
    avlps_kind_t              kind_q [CHAN_N];
    logic [CHAR_W-1:0]        char_d [CHAN_N];
    logic [CHAR_W-1:0]        char_q [CHAN_N];

    ////////////////////////////////////////////////////////////////////////////////
    // Reset and enable crossing into the pixel domain

    always_ff @(posedge i_clk_pix or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pix_rst_q <= 2'h3;
        end else begin
            pix_rst_q <= {pix_rst_q[0], 1'b0};
        end
    end

    assign pix_rst = pix_rst_q[1];

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_sys_q <= 1'b0;
        end else begin
            en_sys_q <= i_sys_enable;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end else begin
            en_meta_q <= en_sys_q;
            en_sync_q <= en_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Period sequencer

    assign in_ctrl  = (state_q == ST_CTRL) || (state_q == ST_PRE);
    assign pre_go   = need_ext_q ? PRE_GO_EXT : PRE_GO_MIN;
    assign pkt_load = (i_isl_pkt_cnt == 5'h00) ? 5'h01 :
                      (i_isl_pkt_cnt > PKT_MAX_CNT) ? PKT_MAX_CNT : i_isl_pkt_cnt;

    always_comb begin
        state_d   = state_q;
        start_vid = 1'b0;
        start_isl = 1'b0;
        unique case (state_q)
            ST_CTRL: begin
                if (en_sync_q && (ctrl_cnt_q >= pre_go)) begin
                    if (i_vid_req) begin
                        state_d   = ST_PRE;
                        start_vid = 1'b1;
                    end else if (i_isl_req) begin
                        state_d   = ST_PRE;
                        start_isl = 1'b1;
                    end
                end
            end
            ST_PRE: begin
                if (pre_cnt_q == PRE_LAST) begin
                    state_d = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (gb_cnt_q == GB_LAST) begin
                    state_d = is_vid_q ? ST_VIDEO : ST_ISLAND;
                end
            end
            ST_VIDEO: begin
                if (!i_vid_req) begin
                    state_d = ST_CTRL;
                end
            end
            ST_ISLAND: begin
                if ((pkt_clk_q == PKT_LAST) && (pkt_left_q == 5'h01)) begin
                    state_d = ST_TRAIL;
                end
            end
            ST_TRAIL: begin
                if (gb_cnt_q == GB_LAST) begin
                    state_d = ST_CTRL;
                end
            end
            default: begin
                state_d = ST_CTRL;
            end
        endcase
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            state_q <= ST_CTRL;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            is_vid_q <= 1'b0;
        end else if (start_vid) begin
            is_vid_q <= 1'b1;
        end else if (start_isl) begin
            is_vid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Period counters

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            ctrl_cnt_q <= 6'h00;
        end else if (!in_ctrl) begin
            ctrl_cnt_q <= 6'h00;
        end else if (ctrl_cnt_q != CNT_SAT) begin
            ctrl_cnt_q <= ctrl_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            pre_cnt_q <= 3'h0;
        end else if (state_q == ST_PRE) begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
        end else begin
            pre_cnt_q <= 3'h0;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            gb_cnt_q <= 1'b0;
        end else if ((state_q == ST_LEAD) || (state_q == ST_TRAIL)) begin
            gb_cnt_q <= ~gb_cnt_q;
        end else begin
            gb_cnt_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            pkt_clk_q <= 5'h00;
        end else if (state_q == ST_ISLAND) begin
            pkt_clk_q <= pkt_clk_q + 5'h01;
        end else begin
            pkt_clk_q <= 5'h00;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            pkt_left_q <= 5'h00;
        end else if (start_isl) begin
            pkt_left_q <= pkt_load;
        end else if ((state_q == ST_ISLAND) && (pkt_clk_q == PKT_LAST)) begin
            pkt_left_q <= pkt_left_q - 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Extended control period tracking

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            ext_tmr_q <= '0;
        end else if (in_ctrl && (ctrl_cnt_q == EXT_MARK)) begin
            ext_tmr_q <= P_TMR_W'(EXT_MIN_LEN);
        end else if (ext_tmr_q != {P_TMR_W{1'b1}}) begin
            ext_tmr_q <= ext_tmr_q + P_TMR_W'(1);
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            need_ext_q <= 1'b0;
            late_pix_q <= 1'b0;
        end else begin
            need_ext_q <= ext_tmr_q >= P_TMR_W'(P_EXT_GAP_CYC - P_EXT_MARGIN);
            late_pix_q <= ext_tmr_q >= P_TMR_W'(P_EXT_GAP_CYC);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source handshakes and clock channel

    assign pkt_first_d = (state_d == ST_ISLAND) &&
                         ((state_q != ST_ISLAND) || (pkt_clk_q == PKT_LAST));

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            vid_take_q  <= 1'b0;
            isl_take_q  <= 1'b0;
            pkt_first_q <= 1'b0;
        end else begin
            vid_take_q  <= state_d == ST_VIDEO;
            isl_take_q  <= state_d == ST_ISLAND;
            pkt_first_q <= pkt_first_d;
        end
    end

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            clk_run_q <= 1'b0;
        end else begin
            clk_run_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Symbol selection per channel

    always_comb begin
        flags_out = i_pix_ctl_flags;
        if (state_q == ST_PRE) begin
            flags_out = is_vid_q ? CTL_PRE_VIDEO : CTL_PRE_ISLAND;
        end else if (i_pix_ctl_flags == CTL_PRE_ISLAND) begin
            flags_out = CTL_IDLE;
        end else if ((i_pix_ctl_flags == CTL_ENCRYPTION_ENABLE_CODE) && !i_pix_enc_window) begin
            flags_out = CTL_IDLE;
        end
    end

    assign ctl6    = {flags_out, i_pix_vsync, i_pix_hsync};
    assign isl12   = {i_isl_ch2, i_isl_ch1, ~pkt_first_q, i_isl_hdr_bit,
                      i_pix_vsync, i_pix_hsync};
    assign isl_gb0 = {ISL_GB_CH0_HIGH, i_pix_vsync, i_pix_hsync};

    generate
        for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
            always_comb begin
                kind_d[c] = KIND_CTRL;
                char_d[c] = '0;
                unique case (state_q)
                    ST_LEAD: begin
                        if (is_vid_q) begin
                            kind_d[c] = KIND_GUARD;
                            char_d[c] = (c == 1) ? GB_CH12 : GB_VID_CH02;
                        end else if (c == 0) begin
                            kind_d[c] = KIND_ERROR_REDUCTION_4B10B_CODING;
                            char_d[c] = {6'h00, isl_gb0};
                        end else begin
                            kind_d[c] = KIND_GUARD;
                            char_d[c] = GB_CH12;
                        end
                    end
                    ST_TRAIL: begin
                        if (c == 0) begin
                            kind_d[c] = KIND_ERROR_REDUCTION_4B10B_CODING;
                            char_d[c] = {6'h00, isl_gb0};
                        end else begin
                            kind_d[c] = KIND_GUARD;
                            char_d[c] = GB_CH12;
                        end
                    end
                    ST_VIDEO: begin
                        kind_d[c] = KIND_VIDEO;
                        char_d[c] = {2'h0, i_vid_data[VID_BITS*c +: VID_BITS]};
                    end
                    ST_ISLAND: begin
                        kind_d[c] = KIND_ERROR_REDUCTION_4B10B_CODING;
                        char_d[c] = {6'h00, isl12[ISL_BITS*c +: ISL_BITS]};
                    end
                    default: begin
                        kind_d[c] = KIND_CTRL;
                        char_d[c] = {8'h00, ctl6[CTL_BITS*c +: CTL_BITS]};
                    end
                endcase
            end

            always_ff @(posedge i_clk_pix or posedge pix_rst) begin
                if (pix_rst) begin
                    kind_q[c] <= KIND_CTRL;
                    char_q[c] <= '0;
                end else begin
                    kind_q[c] <= kind_d[c];
                    char_q[c] <= char_d[c];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Status back into the system domain

    always_ff @(posedge i_clk_pix or posedge pix_rst) begin
        if (pix_rst) begin
            act_pix_q <= 1'b0;
        end else begin
            act_pix_q <= en_sync_q || !in_ctrl;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            act_meta_q     <= 1'b0;
            late_meta_q    <= 1'b0;
            o_sys_active   <= 1'b0;
            o_sys_ext_late <= 1'b0;
        end else begin
            act_meta_q     <= act_pix_q;
            late_meta_q    <= late_pix_q;
            o_sys_active   <= act_meta_q;
            o_sys_ext_late <= late_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output wiring from flip-flops

    assign o_vid_take      = vid_take_q;
    assign o_isl_take      = isl_take_q;
    assign o_isl_pkt_first = pkt_first_q;
    assign o_clk_chan_run  = clk_run_q;
    assign o_ch0_kind      = kind_q[0];
    assign o_ch0_char      = char_q[0];
    assign o_ch1_kind      = kind_q[1];
    assign o_ch1_char      = char_q[1];
    assign o_ch2_kind      = kind_q[2];
    assign o_ch2_char      = char_q[2];

endmodule : avlps_seq

// File: tb/avlps_rx_model.sv
`timescale 1ns/100ps
module avlps_rx_model
    import avlps_pkg::*;
(
    // Link side
    input  wire logic              i_clk_pix,
    input  wire logic              i_sys_rst,
    input  wire logic [1:0]        i_ch1_kind,
    input  wire logic [CHAR_W-1:0] i_ch1_char,
    input  wire logic [CHAR_W-1:0] i_ch2_char,
    // Decoded status
    output logic                   o_synced,
    output logic [15:0]            o_vid_cnt,
    output logic [15:0]            o_isl_cnt,
    output logic [15:0]            o_bad_cnt
);
    logic [5:0] run_q;
    logic [3:0] same_q;
    logic [3:0] flg_q;
    logic       ctl_q;
    wire        ctl = i_ch1_kind == KIND_CTRL;
    wire  [3:0] flg = {i_ch2_char[1:0], i_ch1_char[1:0]};
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_pix or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            run_q     <= 6'h00;
            same_q    <= 4'h0;
            flg_q     <= 4'h0;
            ctl_q     <= 1'b0;
            o_synced  <= 1'b0;
            o_vid_cnt <= 16'h0000;
            o_isl_cnt <= 16'h0000;
            o_bad_cnt <= 16'h0000;
        end else begin
            ctl_q  <= ctl;
            flg_q  <= flg;
            run_q  <= !ctl ? 6'h00 : (run_q == 6'h3F ? run_q : run_q + 6'h01);
            same_q <= (ctl && flg == flg_q) ? (same_q == 4'hF ? same_q : same_q + 4'h1) : 4'h1;
            if (ctl && run_q >= 6'h0B) begin
                o_synced <= 1'b1;
            end
            if (ctl_q && i_ch1_kind == KIND_GUARD && o_synced) begin
                if (same_q >= 4'h8 && flg_q == 4'h1) begin
                    o_vid_cnt <= o_vid_cnt + 16'h0001;
                end else if (same_q >= 4'h8 && flg_q == 4'h5) begin
                    o_isl_cnt <= o_isl_cnt + 16'h0001;
                end else begin
                    o_bad_cnt <= o_bad_cnt + 16'h0001;
                end
            end
        end
    end
endmodule : avlps_rx_model

// File: tb/avlps_seq_chk.sv
`timescale 1ns/100ps
module avlps_seq_chk
    import avlps_pkg::*;
#(
    parameter int unsigned P_EXT_GAP_CYC = EXT_GAP_CYC
) (
    // Pixel domain inputs
    input  wire logic              i_clk_pix,
    input  wire logic              i_sys_rst,
    input  wire logic              i_pix_hsync,
    input  wire logic              i_pix_vsync,
    input  wire logic              i_pix_enc_window,
    input  wire logic [23:0]       i_vid_data,
    input  wire logic              i_isl_hdr_bit,
    input  wire logic [3:0]        i_isl_ch1,
    input  wire logic [3:0]        i_isl_ch2,
    // Design outputs
    input  wire logic              o_vid_take,
    input  wire logic              o_isl_take,
    input  wire logic              o_isl_pkt_first,
    input  wire logic              o_clk_chan_run,
    input  wire logic [1:0]        o_ch0_kind,
    input  wire logic [CHAR_W-1:0] o_ch0_char,
    input  wire logic [1:0]        o_ch1_kind,
    input  wire logic [CHAR_W-1:0] o_ch1_char,
    input  wire logic [1:0]        o_ch2_kind,
    input  wire logic [CHAR_W-1:0] o_ch2_char
);
    default clocking cb @(posedge i_clk_pix);
    endclocking
    default disable iff (i_sys_rst);

    logic [5:0]  ctl_q;
    logic [5:0]  tk_q;
    int unsigned gap_q;
    wire         ctl   = o_ch1_kind == KIND_CTRL;
    wire  [3:0]  flg   = {o_ch2_char[1:0], o_ch1_char[1:0]};
    wire         isl_p = ctl && flg == 4'h5;
    wire         vid_p = ctl && flg == 4'h1;
    ////////////////////////////////////////////////////////////////////////////////
    // Control run length, packet clock count, clocks since extended control
    always_ff @(posedge i_clk_pix or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_q <= 6'h00;
            tk_q  <= 6'h00;
            gap_q <= 0;
        end else begin
            ctl_q <= !ctl ? 6'h00 : (ctl_q == 6'h3F ? ctl_q : ctl_q + 6'h01);
            tk_q  <= o_isl_pkt_first ? 6'h01 : (o_isl_take ? tk_q + 6'h01 : 6'h00);
            gap_q <= (ctl_q >= 6'h20) ? 0 : gap_q + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_isl_preamble: assert property (
        $rose(isl_p) |-> isl_p [*8] ##1 o_ch1_kind == KIND_GUARD)
        else $error("island code outside a full preamble");
    a_vid_preamble: assert property (
        $rose(vid_p) |-> vid_p [*8] ##1 o_ch0_kind == KIND_GUARD)
        else $error("video preamble not eight long");
    a_enc_window: assert property (
        ctl && flg == 4'h9 |-> $past(i_pix_enc_window))
        else $error("encryption code outside window");
    a_guard_two: assert property (
        $rose(o_ch1_kind == KIND_GUARD) |-> ##1 o_ch1_kind == KIND_GUARD
            ##1 o_ch1_kind != KIND_GUARD)
        else $error("guard band not two characters");
    a_vid_guard: assert property (
        o_ch0_kind == KIND_GUARD |-> o_ch0_char == 10'h2CC && o_ch1_char == 10'h133
            && o_ch2_char == 10'h2CC)
        else $error("video guard character wrong");
    a_isl_guard: assert property (
        o_ch1_kind == KIND_GUARD && o_ch0_kind == KIND_ERROR_REDUCTION_4B10B_CODING |-> o_ch2_char == 10'h133
            && o_ch0_char[3:0] == {2'h3, $past(i_pix_vsync), $past(i_pix_hsync)})
        else $error("island guard character wrong");
    a_vid_data: assert property (
        o_vid_take |=> {o_ch2_kind, o_ch1_kind} == {2{KIND_VIDEO}}
            && {o_ch2_char[7:0], o_ch1_char[7:0], o_ch0_char[7:0]} == $past(i_vid_data))
        else $error("pixel not carried");
    a_isl_data: assert property (
        o_isl_take |=> {o_ch2_kind, o_ch1_kind} == {2{KIND_ERROR_REDUCTION_4B10B_CODING}}
            && {o_ch2_char[3:0], o_ch1_char[3:0]} == $past({i_isl_ch2, i_isl_ch1})
            && o_ch0_char[3:0] == $past({~o_isl_pkt_first, i_isl_hdr_bit,
            i_pix_vsync, i_pix_hsync}))
        else $error("island bits not carried");
    a_ctrl_min: assert property (
        ctl_q != 6'h00 && !ctl |-> ctl_q >= 6'h0C)
        else $error("control period too short");
    a_pkt_len: assert property (
        $fell(o_isl_take) || (o_isl_pkt_first && tk_q != 6'h00) |-> tk_q == 6'h20)
        else $error("packet not 32 clocks");
    a_ext_gap: assert property (
        gap_q <= P_EXT_GAP_CYC)
        else $error("extended control overdue");
    a_clk_run: assert property (
        o_clk_chan_run |=> o_clk_chan_run)
        else $error("clock channel stopped");
    c_video: cover property ($rose(o_vid_take));
    c_island: cover property (o_isl_pkt_first && tk_q == 6'h20);
    c_enc: cover property (ctl && flg == 4'h9);
endmodule : avlps_seq_chk

bind avlps_seq avlps_seq_chk #(.P_EXT_GAP_CYC(P_EXT_GAP_CYC)) u_chk (
    .i_clk_pix(i_clk_pix), .i_sys_rst(i_sys_rst), .i_pix_hsync(i_pix_hsync),
    .i_pix_vsync(i_pix_vsync), .i_pix_enc_window(i_pix_enc_window),
    .i_vid_data(i_vid_data), .i_isl_hdr_bit(i_isl_hdr_bit), .i_isl_ch1(i_isl_ch1),
    .o_vid_take(o_vid_take), .o_isl_take(o_isl_take), .o_isl_pkt_first(o_isl_pkt_first),
    .o_clk_chan_run(o_clk_chan_run), .o_ch0_kind(o_ch0_kind), .o_ch0_char(o_ch0_char),
    .i_isl_ch2(i_isl_ch2), .o_ch2_kind(o_ch2_kind),
    .o_ch1_kind(o_ch1_kind), .o_ch1_char(o_ch1_char), .o_ch2_char(o_ch2_char));

// File: tb/test_av_link_period_sequencer.sv
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: %s", $time, m); end end
module test_av_link_period_sequencer;
    import avlps_pkg::*;
    logic        clk_sys, clk_pix, rst = 1'b1, en = 1'b0, vreq = 1'b0, ireq = 1'b0;
    logic        hs = 1'b0, vs = 1'b0, win = 1'b0, hdr = 1'b0;
    logic [3:0]  flags = 4'h0, ich1 = 4'h0, ich2 = 4'h0;
    logic [4:0]  pcnt = 5'h00;
    logic [23:0] vdata = 24'h000000;
    logic        active, late, vtake, itake, pfirst, run, synced;
    logic [1:0]  k0, k1, k2;
    logic [9:0]  c0, c1, c2;
    logic [15:0] nvid, nisl, nbad;
    logic [4:0]  itab [5];
    int          err_count = 0, n_compared = 0, vt_cnt = 0, it_cnt = 0, pf_cnt = 0, v0;

    avlps_seq #(.P_EXT_GAP_CYC(2000), .P_EXT_MARGIN(200)) u_dut (
        .i_clk_sys(clk_sys), .i_sys_rst(rst), .i_sys_enable(en), .o_sys_active(active),
        .o_sys_ext_late(late), .i_clk_pix(clk_pix), .i_pix_hsync(hs), .i_pix_vsync(vs),
        .i_pix_ctl_flags(flags), .i_pix_enc_window(win), .i_vid_req(vreq),
        .i_vid_data(vdata), .o_vid_take(vtake), .i_isl_req(ireq), .i_isl_pkt_cnt(pcnt),
        .i_isl_hdr_bit(hdr), .i_isl_ch1(ich1), .i_isl_ch2(ich2), .o_isl_take(itake),
        .o_isl_pkt_first(pfirst), .o_clk_chan_run(run), .o_ch0_kind(k0), .o_ch0_char(c0),
        .o_ch1_kind(k1), .o_ch1_char(c1), .o_ch2_kind(k2), .o_ch2_char(c2));
    avlps_rx_model u_rx (
        .i_clk_pix(clk_pix), .i_sys_rst(rst), .i_ch1_kind(k1), .i_ch1_char(c1),
        .i_ch2_char(c2), .o_synced(synced), .o_vid_cnt(nvid), .o_isl_cnt(nisl),
        .o_bad_cnt(nbad));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        clk_pix = 1'b0;
        #1.3;
        forever #3 clk_pix = ~clk_pix;
    end
    always @(negedge clk_pix) begin
        flags        <= 4'($urandom_range(15, 2));
        {hs, vs, win, hdr} <= 4'($urandom);
        vdata        <= 24'($urandom);
        {ich1, ich2} <= 8'($urandom);
    end
    always @(posedge clk_pix) begin
        if (vtake === 1'b1) vt_cnt++;
        if (itake === 1'b1) it_cnt++;
        if (pfirst === 1'b1) pf_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic int exp_pkts(input logic [4:0] n);
        return (n == 5'h00) ? 1 : ((n > 5'h12) ? 18 : int'(n));
    endfunction : exp_pkts
    task automatic stop_test;
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic wait_hi(input logic vid);
        int t;
        t = 0;
        while (((vid ? vtake : itake) !== 1'b1) && t < 200) begin
            @(negedge clk_pix);
            t++;
        end
        `CHK(t < 200, 1'b1, "no take")
    endtask : wait_hi
    task automatic video(input int len, input logic both);
        int          s0, i0;
        logic [15:0] n0;
        s0 = vt_cnt;
        i0 = it_cnt;
        n0 = nvid;
        vreq = 1'b1;
        ireq = both;
        wait_hi(1'b1);
        ireq = 1'b0;
        repeat (len - 1) @(negedge clk_pix);
        vreq = 1'b0;
        repeat (4) @(negedge clk_pix);
        `CHK(vt_cnt - s0, len, "video length")
        `CHK(it_cnt - i0, 0, "video priority")
        `CHK(nvid - n0, 16'h0001, "video periods")
    endtask : video
    task automatic island(input logic [4:0] n);
        int          i0, f0;
        logic [15:0] n0;
        i0 = it_cnt;
        f0 = pf_cnt;
        n0 = nisl;
        ireq = 1'b1;
        pcnt = n;
        wait_hi(1'b0);
        ireq = 1'b0;
        repeat (32 * exp_pkts(n) + 8) @(negedge clk_pix);
        `CHK(it_cnt - i0, 32 * exp_pkts(n), "island length")
        `CHK(pf_cnt - f0, exp_pkts(n), "packet count")
        `CHK(nisl - n0, 16'h0001, "island periods")
    endtask : island
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        err_count++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h0AB50C75));
        itab = '{5'h00, 5'h01, 5'h12, 5'h1F, 5'h03};
        itab[4] = 5'($urandom_range(17, 2));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        en = 1'b1;
        repeat (40) @(negedge clk_pix);
        `CHK(active, 1'b1, "not active")
        `CHK(synced, 1'b1, "receiver not in sync")
        video(1, 1'b0);
        video(7, 1'b1);
        foreach (itab[i]) island(itab[i]);
        @(negedge clk_sys) en = 1'b0;
        repeat (20) @(negedge clk_pix);
        v0 = vt_cnt;
        vreq = 1'b1;
        repeat (60) @(negedge clk_pix);
        `CHK(vt_cnt, v0, "video while disabled")
        `CHK(active, 1'b0, "active while disabled")
        vreq = 1'b0;
        @(negedge clk_sys) en = 1'b1;
        repeat (40) @(negedge clk_pix);
        for (int i = 0; i < 40; i++) video(32 + $urandom_range(15, 0), 1'b0);
        `CHK(late, 1'b0, "extended control late")
        `CHK(nbad, 16'h0000, "illegal preamble")
        `CHK(run, 1'b1, "clock channel idle")
        stop_test;
    end
endmodule : test_av_link_period_sequencer
